// >>> verilog/wdt_pkg.sv
/*
 * package for the watchdog timer: register offsets, field positions,
 * reset values and the register bus carrier types.
 * assumes a single 20 MHz clock and a plain register port with
 * read data returned one cycle after the read strobe.
 */
// Summary of operation
// (RULE1) first zero reloads counter from reload value and counting resumes
// (RULE2) reload write while running copies value into counter at once
// (RULE3) writing reload value zero raises the interrupt at once
// (RULE4) while locked, writes to configuration registers are ignored
// (RULE5) software unlock command releases the lock, writes accepted again
// (RULE6) reset enable bit gates whether second timeout asserts reset
// (RULE7) with stall enabled, counter freezes while debugger halts processor
// (RULE8) with stall disabled, counter keeps counting during debug halt
// (RULE9) software can read whether the counter is enabled
// (RULE10) software can read current count without disturbing it
// (RULE11) timeout counter is a 32 bit down counter
// (RULE12) enabling the counter also enables the watchdog interrupt
// (RULE13) second zero with interrupt pending and reset enabled asserts reset
// (RULE14) clearing interrupt before second timeout reloads and keeps counting
package wdt_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] WDT_REG_RELOAD = 8'h00;
    localparam logic [7:0] WDT_REG_VALUE = 8'h04;
    localparam logic [7:0] WDT_REG_CTRL = 8'h08;
    localparam logic [7:0] WDT_REG_LOCK = 8'h0c;
    localparam logic [7:0] WDT_REG_STAT = 8'h10;
    localparam logic [7:0] WDT_REG_ICLR = 8'h14;
    localparam logic [7:0] WDT_REG_IEN = 8'h18;
    localparam logic [7:0] WDT_REG_MIS = 8'h1c;

    // ****************************************
    // field positions
    // ****************************************
    localparam int WDT_CTRL_EN = 0;
    localparam int WDT_CTRL_INTEN = 1;
    localparam int WDT_CTRL_RSTEN = 2;
    localparam int WDT_CTRL_STALL = 3;
    localparam int WDT_CTRL_W = 4;
    localparam int WDT_EV_TIMEOUT = 0;
    localparam int WDT_EV_RESET = 1;
    localparam int WDT_EV_W = 2;

    // ****************************************
    // reset values and command keys
    // ****************************************
    localparam logic [31:0] WDT_RELOAD_RST = 32'hffff_ffff;
    localparam logic [31:0] WDT_UNLOCK_KEY = 32'h1acc_e551;
    localparam logic [WDT_CTRL_W-1:0] WDT_CTRL_RST = 4'h0;
    localparam logic [WDT_EV_W-1:0] WDT_EV_RST = 2'h0;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } wdt_req_t;

endpackage

// >>> verilog/wdt_sticky.sv
/*
 * one sticky status bit: set by a hardware event, cleared by software.
 * assumes synchronous active-high reset; set wins over clear.
 */
`timescale 1ns/100ps
`default_nettype none
module wdt_sticky (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_o <= 1'b0;
        end else if (set_i) begin
            q_o <= 1'b1;
        end else if (clr_i) begin
            q_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/wdt_top.sv
/*
 * watchdog timer: 32 bit down counter, reload register, lock,
 * debug stall, first-timeout interrupt and second-timeout reset.
 * assumes one 20 MHz clock, synchronous reset, synchronous inputs,
 * and a register port master that never issues read and write together.
 */
`timescale 1ns/100ps
`default_nettype none
module wdt_top (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire wdt_pkg::wdt_req_t req_i,
    input wire logic dbg_halt_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic sys_rst_o
);
    import wdt_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [31:0] count_q;
    logic [31:0] reload_q;
    logic [WDT_CTRL_W-1:0] ctrl_q;
    logic lock_q;
    logic [WDT_EV_W-1:0] ev_en_q;
    logic [WDT_EV_W-1:0] ev_stat;
    logic [WDT_EV_W-1:0] ev_set;
    logic wr_cfg;
    logic wr_reload;
    logic wr_ctrl;
    logic wr_iclr;
    logic running;
    logic tick;
    logic zero_hit;
    logic first_to;
    logic second_to;
    logic to_pend_q;

    assign wr_cfg = req_i.wr && !lock_q;
    assign wr_reload = wr_cfg && (req_i.addr == WDT_REG_RELOAD); // see (RULE4)
    assign wr_ctrl = wr_cfg && (req_i.addr == WDT_REG_CTRL); // see (RULE4)
    assign wr_iclr = req_i.wr && (req_i.addr == WDT_REG_ICLR);
    assign running = ctrl_q[WDT_CTRL_EN];
    // see (RULE7) see (RULE8)
    assign tick = running && !(ctrl_q[WDT_CTRL_STALL] && dbg_halt_i);
    assign zero_hit = tick && (count_q == 32'h0000_0000) && !wr_reload;
    assign first_to = zero_hit && !to_pend_q;
    assign second_to = zero_hit && to_pend_q;

    // ****************************************
    // configuration and lock
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reload_q <= WDT_RELOAD_RST;
        end else if (wr_reload) begin
            reload_q <= req_i.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_q <= WDT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= req_i.wdata[WDT_CTRL_W-1:0];
            // enable cannot be withdrawn once set; enabling also enables irq
            if (req_i.wdata[WDT_CTRL_EN] || ctrl_q[WDT_CTRL_EN]) begin
                ctrl_q[WDT_CTRL_EN] <= 1'b1;
                ctrl_q[WDT_CTRL_INTEN] <= 1'b1; // see (RULE12)
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock_q <= 1'b0;
        end else if (req_i.wr && req_i.addr == WDT_REG_LOCK) begin
            lock_q <= (req_i.wdata != WDT_UNLOCK_KEY); // see (RULE5)
        end
    end

    // ****************************************
    // down counter
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_q <= WDT_RELOAD_RST;
        end else if (wr_reload) begin
            count_q <= req_i.wdata; // see (RULE2)
        end else if (wr_ctrl && !running && req_i.wdata[WDT_CTRL_EN]) begin
            count_q <= reload_q;
        end else if (wr_iclr && req_i.wdata[WDT_EV_TIMEOUT] && to_pend_q && running) begin
            count_q <= reload_q; // see (RULE14)
        end else if (zero_hit) begin
            count_q <= reload_q; // see (RULE1)
        end else if (tick) begin
            count_q <= count_q - 32'h0000_0001; // see (RULE11)
        end
    end

    // ****************************************
    // timeout, interrupt and reset
    // ****************************************
    // a pending timeout is the raw interrupt; the sticky bit mirrors it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            to_pend_q <= 1'b0;
        end else if (first_to || (wr_reload && req_i.wdata == 32'h0000_0000)) begin
            to_pend_q <= 1'b1; // see (RULE3)
        end else if (wr_iclr && req_i.wdata[WDT_EV_TIMEOUT]) begin
            to_pend_q <= 1'b0;
        end
    end

    assign ev_set[WDT_EV_TIMEOUT] = first_to || (wr_reload && req_i.wdata == 32'h0000_0000);
    assign ev_set[WDT_EV_RESET] = second_to && ctrl_q[WDT_CTRL_RSTEN]; // see (RULE6)

    genvar gi;
    generate
        for (gi = 0; gi < WDT_EV_W; gi++) begin : g_ev
            wdt_sticky u_sticky (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .set_i(ev_set[gi]),
                .clr_i(wr_iclr && req_i.wdata[gi]),
                .q_o(ev_stat[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ev_en_q <= WDT_EV_RST;
        end else if (wr_cfg && req_i.addr == WDT_REG_IEN) begin
            ev_en_q <= req_i.wdata[WDT_EV_W-1:0]; // see (RULE4)
        end else if (wr_ctrl && req_i.wdata[WDT_CTRL_EN]) begin
            ev_en_q[WDT_EV_TIMEOUT] <= 1'b1; // see (RULE12)
        end
    end

    // timeout interrupt also needs the control interrupt enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ev_stat & ev_en_q & {1'b1, ctrl_q[WDT_CTRL_INTEN]});
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sys_rst_o <= 1'b0;
        end else begin
            sys_rst_o <= ev_set[WDT_EV_RESET]; // see (RULE13)
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (req_i.rd) begin
            case (req_i.addr)
                WDT_REG_RELOAD: rdata_o <= reload_q;
                WDT_REG_VALUE: rdata_o <= count_q; // see (RULE10)
                WDT_REG_CTRL: rdata_o <= {28'h0, ctrl_q}; // see (RULE9)
                WDT_REG_LOCK: rdata_o <= {31'h0, lock_q};
                WDT_REG_STAT: rdata_o <= {30'h0, ev_stat};
                WDT_REG_IEN: rdata_o <= {30'h0, ev_en_q};
                WDT_REG_MIS: rdata_o <= {30'h0, ev_stat & ev_en_q};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// >>> tb/wdt_assertions.sv
/* checker for wdt_top port behaviour.
   assumes the bind below and one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module wdt_chk (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire wdt_pkg::wdt_req_t req_i,
    input wire logic dbg_halt_i,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o,
    input wire logic sys_rst_o
);
    import wdt_pkg::*;
    logic lk_q, en_q, st_q;
    logic [31:0] rl_q;
    wire logic rd = req_i.rd;
    wire logic [7:0] ad = req_i.addr;
    wire logic wu = req_i.wr && !lk_q;
    wire logic rv = rd && ad == WDT_REG_VALUE;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lk_q <= 1'b0;
            en_q <= 1'b0;
            st_q <= 1'b0;
            rl_q <= WDT_RELOAD_RST;
        end else begin
            if (req_i.wr && ad == WDT_REG_LOCK) lk_q <= req_i.wdata != WDT_UNLOCK_KEY;
            if (wu && ad == WDT_REG_RELOAD) rl_q <= req_i.wdata;
            if (wu && ad == WDT_REG_CTRL) en_q <= en_q | req_i.wdata[0];
            if (wu && ad == WDT_REG_CTRL) st_q <= req_i.wdata[3];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_rdata_idle: assert property (!$past(rd) |-> rdata_o == 32'h0)
        else $error("rdata not idle");
    a_rst_pulse: assert property (sys_rst_o && rl_q != 32'h0 |=> !sys_rst_o)
        else $error("reset pulse too long");
    a_lock_read: assert property (rd && ad == WDT_REG_LOCK |=> rdata_o[0] == lk_q)
        else $error("lock state wrong");
    a_run_flag: assert property (rd && ad == WDT_REG_CTRL |=> rdata_o[0] == en_q)
        else $error("enable flag wrong");
    a_stall_bit: assert property (rd && ad == WDT_REG_CTRL |=> rdata_o[3] == st_q)
        else $error("stall bit wrong");
    a_reload_read: assert property (rd && ad == WDT_REG_RELOAD |=> rdata_o == rl_q)
        else $error("reload value wrong");
    a_zero_irq: assert property (wu && ad == WDT_REG_RELOAD && req_i.wdata == 32'h0
        ##1 !req_i.wr ##1 rd && ad == WDT_REG_STAT |=> rdata_o[0])
        else $error("zero reload no event");
    a_count_freeze: assert property (en_q && st_q && dbg_halt_i && rv
        ##1 dbg_halt_i && rv |=> rdata_o == $past(rdata_o)) else $error("count moved");
    a_count_down: assert property (en_q && !st_q && rv ##1 rv
        |=> $past(rdata_o) == 32'h0 || rdata_o == $past(rdata_o) - 32'h1)
        else $error("count not down");
    c_reset: cover property (sys_rst_o);
    c_irq: cover property ($rose(irq_o));
    c_freeze: cover property (dbg_halt_i && rv);
endmodule
bind wdt_top wdt_chk i_wdt_chk (.clk_i, .srst_i, .req_i, .dbg_halt_i, .rdata_o, .irq_o,
    .sys_rst_o);
`default_nettype wire

// >>> tb/tb.sv
/* self-checking bench for wdt_top over its register port.
   assumes the checker binds itself from its own file. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import wdt_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    wdt_req_t req_i = '0;
    logic dbg_halt_i = 1'b0;
    logic [31:0] rdata_o, v1, v2;
    logic irq_o, sys_rst_o;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    wdt_top i_wdt_top (.clk_i, .srst_i, .req_i, .dbg_halt_i, .rdata_o, .irq_o, .sys_rst_o);
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        req_i <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        req_i <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i);
        req_i <= '0;
        @(posedge clk_i);
        chk(rdata_o, e);
    endtask
    task automatic rdv();
        req_i <= '{WDT_REG_VALUE, 32'h0, 1'b0, 1'b1};
        repeat (2) @(posedge clk_i);
        v1 = rdata_o;
        req_i <= '0;
        @(posedge clk_i);
        v2 = rdata_o;
    endtask
    task automatic wt(input logic r);
        n = 0;
        while ((r ? sys_rst_o : irq_o) !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, n < 2000}, 32'h1);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(WDT_REG_RELOAD, WDT_RELOAD_RST);
        rd(WDT_REG_VALUE, WDT_RELOAD_RST);
        wr(WDT_REG_RELOAD, 32'h0);
        rd(WDT_REG_STAT, 32'h1);
        wr(WDT_REG_ICLR, 32'h1);
        rd(WDT_REG_STAT, 32'h0);
        wr(WDT_REG_RELOAD, 32'd1000);
        wr(WDT_REG_CTRL, 32'h1);
        rd(WDT_REG_CTRL, 32'h3);
        rd(WDT_REG_IEN, 32'h1);
        wr(WDT_REG_RELOAD, 32'd500);
        rdv();
        chk({31'h0, v1 > 32'd490 && v1 <= 32'd500}, 32'h1);
        wr(WDT_REG_CTRL, 32'hb);
        dbg_halt_i <= 1'b1;
        rdv();
        chk(v2, v1);
        wr(WDT_REG_CTRL, 32'h3);
        rdv();
        chk(v2, v1 - 32'h1);
        dbg_halt_i <= 1'b0;
        wr(WDT_REG_IEN, 32'h1);
        wt(1'b0);
        rdv();
        chk({31'h0, v1 > 32'd400}, 32'h1);
        repeat (200) @(posedge clk_i);
        wr(WDT_REG_ICLR, 32'h1);
        rdv();
        chk({31'h0, v1 > 32'd400}, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wt(1'b0);
        n = 0;
        repeat (1200) begin
            @(posedge clk_i);
            if (sys_rst_o !== 1'b0) n++;
        end
        chk(n, 0);
        wr(WDT_REG_CTRL, 32'h7);
        wt(1'b1);
        rd(WDT_REG_STAT, 32'h3);
        rd(WDT_REG_MIS, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(WDT_REG_ICLR, 32'h2);
        rd(WDT_REG_STAT, 32'h1);
        wr(WDT_REG_LOCK, 32'h0);
        rd(WDT_REG_LOCK, 32'h1);
        wr(WDT_REG_RELOAD, 32'h55);
        rd(WDT_REG_RELOAD, 32'd500);
        wr(WDT_REG_CTRL, 32'h1);
        rd(WDT_REG_CTRL, 32'h7);
        wr(WDT_REG_IEN, 32'h0);
        rd(WDT_REG_IEN, 32'h1);
        wr(WDT_REG_LOCK, WDT_UNLOCK_KEY);
        wr(WDT_REG_RELOAD, 32'h55);
        rd(WDT_REG_RELOAD, 32'h55);
        summarize();
    end
endmodule
`default_nettype wire
